// ### rtl/mfthf_pkg.sv
// Shared constants for the field threshold flag device and its SPI host
package mfthf_pkg;
  // Clock rate and timing figures
  localparam int CLK_MHZ = 100;
  localparam int GLITCH_NS = 1400;
  localparam int GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int GLITCH_GAP_US = 100;
  localparam int GLITCH_GAP_CYC = GLITCH_GAP_US * CLK_MHZ;
  localparam int RESAMPLE_US = 20;
  localparam int RESAMPLE_CYC = RESAMPLE_US * CLK_MHZ;
  localparam logic [2:0] SCLK_HALF_CYC = 3'h4;
  localparam logic [2:0] FRAME_GAP_CYC = 3'h4;

  // Device register offsets
  localparam logic [4:0] REG_THRESH = 5'h06;
  localparam logic [4:0] REG_STATUS = 5'h1b;
  localparam logic [4:0] REG_TRIM_VAL = 5'h0a;
  localparam logic [4:0] REG_TRIM_EN = 5'h0b;

  // Device reset values
  localparam logic [7:0] THRESH_RESET = 8'h1c;
  localparam logic [7:0] TRIM_VAL_RESET = 8'h00;
  localparam logic [1:0] TRIM_EN_RESET = 2'h0;

  // Field positions
  localparam int LOW_CODE_LSB = 5;
  localparam int HIGH_CODE_LSB = 2;
  localparam int STAT_HIGH_BIT = 7;
  localparam int STAT_LOW_BIT = 6;
  localparam int AUX_A_BIT = 3;
  localparam int AUX_B_BIT = 2;
  localparam int TRIM_X_BIT = 0;
  localparam int TRIM_Y_BIT = 1;

  // SPI frame layout
  localparam logic [2:0] CMD_READ = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [3:0] FRAME_LAST_BIT = 4'hf;

  // Field hysteresis in mT
  localparam logic [7:0] HYST_MT = 8'h06;

  // Output angle windows for the spurious low flag pulses, 16-bit full turn
  localparam logic [15:0] DEFECT_ANGLE [4] = '{16'h1f4a, 16'h6222, 16'h9f4a, 16'he222};
  localparam logic [15:0] DEFECT_SPAN = 16'h0111;

  // Host register offsets
  localparam logic [3:0] HREG_CMD = 4'h0;
  localparam logic [3:0] HREG_RESULT = 4'h1;
  localparam logic [3:0] HREG_FLAGS = 4'h2;

  // Rising-field switching point for a threshold code
  function automatic logic [7:0] mfthf_rise_mt(input logic [2:0] code);
    logic [7:0] mt;
    mt = 8'h1a;
    case (code)
      3'h0: mt = 8'h1a;
      3'h1: mt = 8'h29;
      3'h2: mt = 8'h38;
      3'h3: mt = 8'h46;
      3'h4: mt = 8'h54;
      3'h5: mt = 8'h62;
      3'h6: mt = 8'h70;
      default: mt = 8'h7e;
    endcase
    return mt;
  endfunction
endpackage

// ### rtl/mfthf_if.sv
// SPI link and flag pins between the sensor device and its host
`timescale 1ns/10ps
`default_nettype none
interface mfthf_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic field_low_flag;
  logic field_high_flag;

  modport dev (input sclk, input cs_n, input mosi, output miso, output field_low_flag, output field_high_flag);
  modport host (output sclk, output cs_n, output mosi, input miso, input field_low_flag, input field_high_flag);
endinterface
`default_nettype wire

// ### rtl/mfthf_dev.sv
// Field threshold flags, trim enables and SPI register slave of the sensor
// Function
// - X trim enable applies bias reduction to X
// - Y trim enable applies bias reduction to Y
// - Both enables reduce both axes equally
// - Low flag below low, high flag above high
// - Both flags switch with 6 mT hysteresis
// - Two 3-bit codes packed in threshold register
// - Codes map to 26..126 rising, 20..120 falling
// - Inverted codes allowed, flags evaluated independently
// - Flags at status bits 7,6 and pins
// - Host reads flags with 010, 11011, zeros
// - Read byte returned in the next frame
// - Flags never alter the angle output
// - Low flag shows spurious 1.3-1.5 us pulses
// - Pulses only near four angles, 100 us apart
// - Host may use inverted high flag instead
// - Host resamples a 1 within 2-100 us
// - Host corrects low flag as NOR of aux bits
`timescale 1ns/10ps
`default_nettype none
module mfthf_dev #(
  parameter int GLITCH_GAP = mfthf_pkg::GLITCH_GAP_CYC
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  mfthf_if.dev link,
  input wire logic [7:0] i_field_mt,
  input wire logic [15:0] i_angle,
  input wire logic i_defect_en,
  output logic [7:0] o_x_trim_value,
  output logic [7:0] o_y_trim_value,
  output logic [15:0] o_angle
);
  logic sclk_prev_q;
  logic cs_prev_q;
  logic [14:0] shift_in_q;
  logic [3:0] bit_cnt_q;
  logic [15:0] shift_out_q;
  logic [15:0] resp_q;
  logic [15:0] resp_d;
  logic miso_q;
  logic [7:0] thresh_q;
  logic [7:0] trim_val_q;
  logic [1:0] trim_en_q;
  logic low_q;
  logic high_q;
  logic low_pin_q;
  logic high_pin_q;
  logic [7:0] glitch_cnt_q;
  logic [15:0] gap_cnt_q;
  logic [3:0] in_win;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic frame_end;
  logic [15:0] word;
  logic [2:0] cmd;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic [2:0] low_code;
  logic [2:0] high_code;
  logic [7:0] low_rise;
  logic [7:0] low_fall;
  logic [7:0] high_rise;
  logic [7:0] high_fall;
  logic glitch_start;
  logic [7:0] status_byte;
  logic [7:0] rd_byte;

  // Link edge detection
  assign sclk_rise = link.sclk & ~sclk_prev_q & ~link.cs_n;
  assign sclk_fall = ~link.sclk & sclk_prev_q & ~link.cs_n;
  assign cs_fall = ~link.cs_n & cs_prev_q;
  assign frame_end = sclk_rise & (bit_cnt_q == mfthf_pkg::FRAME_LAST_BIT);
  assign word = {shift_in_q, link.mosi};
  assign cmd = word[15:13];
  assign addr = word[12:8];
  assign wdata = word[7:0];

  // Threshold codes and switching points
  assign low_code = thresh_q[mfthf_pkg::LOW_CODE_LSB +: 3];
  assign high_code = thresh_q[mfthf_pkg::HIGH_CODE_LSB +: 3];
  assign low_rise = mfthf_pkg::mfthf_rise_mt(low_code);
  assign high_rise = mfthf_pkg::mfthf_rise_mt(high_code);
  assign low_fall = low_rise - mfthf_pkg::HYST_MT;
  assign high_fall = high_rise - mfthf_pkg::HYST_MT;

  // Angle windows where the spurious low pulses can appear
  for (genvar i = 0; i < 4; i++) begin : g_win
    assign in_win[i] = (i_angle >= mfthf_pkg::DEFECT_ANGLE[i] - mfthf_pkg::DEFECT_SPAN) &&
                       (i_angle <= mfthf_pkg::DEFECT_ANGLE[i] + mfthf_pkg::DEFECT_SPAN);
  end
  assign glitch_start = i_defect_en & (|in_win) & (gap_cnt_q == 16'h0000) & (glitch_cnt_q == 8'h00);

  // Status byte: pin flags on top, aux bits carry the clean low flag inverted
  always_comb begin
    status_byte = 8'h00;
    status_byte[mfthf_pkg::STAT_HIGH_BIT] = high_pin_q;
    status_byte[mfthf_pkg::STAT_LOW_BIT] = low_pin_q;
    status_byte[mfthf_pkg::AUX_A_BIT] = ~low_q;
    status_byte[mfthf_pkg::AUX_B_BIT] = ~low_q;
  end

  // Register read mux, free of side effects
  always_comb begin
    rd_byte = 8'h00;
    case (addr)
      mfthf_pkg::REG_THRESH: rd_byte = thresh_q;
      mfthf_pkg::REG_STATUS: rd_byte = status_byte;
      mfthf_pkg::REG_TRIM_VAL: rd_byte = trim_val_q;
      mfthf_pkg::REG_TRIM_EN: rd_byte = {6'h00, trim_en_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // Answer for the next frame
  always_comb begin
    resp_d = 16'h0000;
    case (cmd)
      mfthf_pkg::CMD_READ: resp_d = {rd_byte, 8'h00};
      mfthf_pkg::CMD_WRITE: resp_d = {wdata, 8'h00};
      default: resp_d = 16'h0000;
    endcase
  end

  // Edge history of the link
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= link.sclk;
      cs_prev_q <= link.cs_n;
    end
  end

  // Receive shifter, sampled on sclk rising edges
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shift_in_q <= 15'h0000;
      bit_cnt_q <= 4'h0;
    end else if (link.cs_n) begin
      bit_cnt_q <= 4'h0;
    end else if (sclk_rise) begin
      shift_in_q <= word[14:0];
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // Response latched when the request frame completes
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      resp_q <= 16'h0000;
    end else if (frame_end) begin
      resp_q <= resp_d;
    end
  end

  // Transmit shifter, loaded at frame start, advanced on sclk falling edges
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shift_out_q <= 16'h0000;
      miso_q <= 1'b0;
    end else if (cs_fall) begin
      miso_q <= resp_q[15];
      shift_out_q <= {resp_q[14:0], 1'b0};
    end else if (sclk_fall) begin
      miso_q <= shift_out_q[15];
      shift_out_q <= {shift_out_q[14:0], 1'b0};
    end
  end

  // Writable configuration
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      thresh_q <= mfthf_pkg::THRESH_RESET;
      trim_val_q <= mfthf_pkg::TRIM_VAL_RESET;
      trim_en_q <= mfthf_pkg::TRIM_EN_RESET;
    end else if (frame_end && cmd == mfthf_pkg::CMD_WRITE) begin
      case (addr)
        mfthf_pkg::REG_THRESH: thresh_q <= {wdata[7:2], 2'h0};
        mfthf_pkg::REG_TRIM_VAL: trim_val_q <= wdata;
        mfthf_pkg::REG_TRIM_EN: trim_en_q <= wdata[1:0];
        default: thresh_q <= thresh_q;
      endcase
    end
  end

  // Trim values per axis; both enabled gives the same reduction on both
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_x_trim_value <= 8'h00;
      o_y_trim_value <= 8'h00;
    end else begin
      o_x_trim_value <= trim_en_q[mfthf_pkg::TRIM_X_BIT] ? trim_val_q : 8'h00;
      o_y_trim_value <= trim_en_q[mfthf_pkg::TRIM_Y_BIT] ? trim_val_q : 8'h00;
    end
  end

  // Low flag: set below falling point, clear at or above rising point
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      low_q <= 1'b0;
    end else if (i_field_mt < low_fall) begin
      low_q <= 1'b1;
    end else if (i_field_mt >= low_rise) begin
      low_q <= 1'b0;
    end
  end

  // High flag: set above rising point, clear at or below falling point
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      high_q <= 1'b0;
    end else if (i_field_mt > high_rise) begin
      high_q <= 1'b1;
    end else if (i_field_mt <= high_fall) begin
      high_q <= 1'b0;
    end
  end

  // Spurious pulse length and spacing
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      glitch_cnt_q <= 8'h00;
      gap_cnt_q <= 16'h0000;
    end else if (glitch_start) begin
      glitch_cnt_q <= 8'(mfthf_pkg::GLITCH_CYC);
      gap_cnt_q <= 16'(GLITCH_GAP);
    end else begin
      if (glitch_cnt_q != 8'h00) begin
        glitch_cnt_q <= glitch_cnt_q - 8'h01;
      end
      if (gap_cnt_q != 16'h0000) begin
        gap_cnt_q <= gap_cnt_q - 16'h0001;
      end
    end
  end

  // Flag pins; the pulse reaches pin and status alike
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      low_pin_q <= 1'b0;
      high_pin_q <= 1'b0;
    end else begin
      low_pin_q <= low_q | glitch_start | (glitch_cnt_q > 8'h01);
      high_pin_q <= high_q;
    end
  end

  // Angle path untouched by the flags
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_angle <= 16'h0000;
    end else begin
      o_angle <= i_angle;
    end
  end

  assign link.miso = miso_q;
  assign link.field_low_flag = low_pin_q;
  assign link.field_high_flag = high_pin_q;
endmodule
`default_nettype wire

// ### rtl/mfthf_host.sv
// SPI host for the field flag device with the low flag workarounds
`timescale 1ns/10ps
`default_nettype none
module mfthf_host (
  input wire logic i_clk,
  input wire logic i_arst_n,
  mfthf_if.host link,
  input wire logic [3:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_XFER = 3'b010,
    S_GAP = 3'b100
  } mfthf_hst_t;

  mfthf_hst_t state_q;
  logic [2:0] tick_q;
  logic [3:0] bit_cnt_q;
  logic [15:0] tx_q;
  logic [15:0] rx_q;
  logic sclk_q;
  logic cs_n_q;
  logic mosi_q;
  logic reply_pending_q;
  logic reply_frame_q;
  logic [4:0] last_addr_q;
  logic [7:0] rdata_q;
  logic nor_low_q;
  logic inv_high_q;
  logic fixed_low_q;
  logic [11:0] res_cnt_q;
  logic start;
  logic tick_done;
  logic [15:0] rx_next;

  assign start = i_reg_wr && (i_reg_addr == mfthf_pkg::HREG_CMD) && (state_q == S_IDLE);
  assign tick_done = (tick_q == 3'h1);
  assign rx_next = {rx_q[14:0], link.miso};

  // Frame sequencer; a read adds a reply frame carrying a null command
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= S_IDLE;
      tick_q <= 3'h0;
      bit_cnt_q <= 4'h0;
      tx_q <= 16'h0000;
      rx_q <= 16'h0000;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
      reply_pending_q <= 1'b0;
      reply_frame_q <= 1'b0;
      last_addr_q <= 5'h00;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (start) begin
            tx_q <= {i_reg_wdata[13] ? mfthf_pkg::CMD_WRITE : mfthf_pkg::CMD_READ,
                     i_reg_wdata[12:0]};
            mosi_q <= i_reg_wdata[13] ? mfthf_pkg::CMD_WRITE[2] : mfthf_pkg::CMD_READ[2];
            reply_pending_q <= ~i_reg_wdata[13];
            reply_frame_q <= 1'b0;
            last_addr_q <= i_reg_wdata[12:8];
            cs_n_q <= 1'b0;
            tick_q <= mfthf_pkg::SCLK_HALF_CYC;
            bit_cnt_q <= 4'h0;
            state_q <= S_XFER;
          end
        end
        S_XFER: begin
          if (tick_done) begin
            tick_q <= mfthf_pkg::SCLK_HALF_CYC;
            if (!sclk_q) begin
              sclk_q <= 1'b1;
              rx_q <= rx_next;
            end else begin
              sclk_q <= 1'b0;
              if (bit_cnt_q == mfthf_pkg::FRAME_LAST_BIT) begin
                cs_n_q <= 1'b1;
                tick_q <= mfthf_pkg::FRAME_GAP_CYC;
                state_q <= S_GAP;
              end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
                tx_q <= {tx_q[14:0], 1'b0};
                mosi_q <= tx_q[14];
              end
            end
          end else begin
            tick_q <= tick_q - 3'h1;
          end
        end
        S_GAP: begin
          if (tick_done) begin
            if (reply_pending_q) begin
              reply_pending_q <= 1'b0;
              reply_frame_q <= 1'b1;
              tx_q <= {mfthf_pkg::CMD_NONE, 13'h0000};
              mosi_q <= 1'b0;
              cs_n_q <= 1'b0;
              tick_q <= mfthf_pkg::SCLK_HALF_CYC;
              bit_cnt_q <= 4'h0;
              state_q <= S_XFER;
            end else begin
              state_q <= S_IDLE;
            end
          end else begin
            tick_q <= tick_q - 3'h1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Read result capture and status-register correction
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= 8'h00;
      nor_low_q <= 1'b0;
    end else if (state_q == S_GAP && tick_done && !reply_pending_q && reply_frame_q) begin
      rdata_q <= rx_q[15:8];
      if (last_addr_q == mfthf_pkg::REG_STATUS) begin
        nor_low_q <= ~(rx_q[8 + mfthf_pkg::AUX_A_BIT] | rx_q[8 + mfthf_pkg::AUX_B_BIT]);
      end
    end
  end

  // Inverted high flag as a low flag substitute
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      inv_high_q <= 1'b0;
    end else begin
      inv_high_q <= ~link.field_high_flag;
    end
  end

  // Low flag resampling: a 1 is confirmed by a second look later
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      res_cnt_q <= 12'h000;
      fixed_low_q <= 1'b0;
    end else if (res_cnt_q == 12'h000) begin
      if (link.field_low_flag) begin
        res_cnt_q <= 12'(mfthf_pkg::RESAMPLE_CYC);
      end else begin
        fixed_low_q <= 1'b0;
      end
    end else if (res_cnt_q == 12'h001) begin
      fixed_low_q <= link.field_low_flag;
      res_cnt_q <= 12'h000;
    end else begin
      res_cnt_q <= res_cnt_q - 12'h001;
    end
  end

  // Register read port, data in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        mfthf_pkg::HREG_RESULT: o_reg_rdata <= {7'h00, state_q != S_IDLE, rdata_q};
        mfthf_pkg::HREG_FLAGS: o_reg_rdata <= {11'h000, nor_low_q, fixed_low_q, inv_high_q,
                                               link.field_low_flag, link.field_high_flag};
        default: o_reg_rdata <= 16'h0000;
      endcase
    end else begin
      o_reg_rdata <= 16'h0000;
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.mosi = mosi_q;
endmodule
`default_nettype wire

// ### tb/mfthf_chk.sv
// Protocol checks on the SPI link between host and sensor device
`timescale 1ns/10ps
`default_nettype none
module mfthf_chk (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic field_low_flag,
  input wire logic field_high_flag
);
  logic sclk_q;
  logic [4:0] bits_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // Previous sclk level for edge detection
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end

  // Rising sclk edges seen within one frame
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) bits_q <= 5'h00;
    else if (cs_n) bits_q <= 5'h00;
    else if (sclk && !sclk_q) bits_q <= bits_q + 5'h01;
  end

  // Link timing and framing
  chk_idle_clock_low: assert property (cs_n |-> !sclk) else $error("sclk high outside a frame");
  chk_frame_gap_len: assert property ($rose(cs_n) |-> cs_n [*4]) else $error("frame gap too short");
  chk_frame_lead_in: assert property ($fell(cs_n) |-> !sclk [*4] ##1 sclk) else $error("bad frame lead");
  chk_sclk_high_phase: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk) else $error("bad sclk high");
  chk_sclk_low_phase: assert property ($fell(sclk) && !cs_n |-> !sclk [*4]) else $error("bad sclk low");
  chk_mosi_hold_high: assert property (sclk && sclk_q |-> $stable(mosi)) else $error("mosi moved");
  chk_miso_hold_high: assert property (!cs_n && sclk && sclk_q |-> $stable(miso)) else $error("miso moved");
  chk_frame_bit_count: assert property ($rose(cs_n) |-> bits_q == 5'h10) else $error("frame not 16 bits");

  // Main scenarios reached
  cov_frame_done: cover property ($rose(cs_n));
  cov_low_flag: cover property ($rose(field_low_flag));
  cov_high_flag: cover property ($rose(field_high_flag));
endmodule
`default_nettype wire

// ### tb/magnetic_field_threshold_flags_tb.sv
// Self-checking bench joining the sensor device and its SPI host
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("[ERR] %0t mismatch got %0h exp %0h", $time, (got), (exp)); end end
module magnetic_field_threshold_flags_tb;
  localparam int GAP = 300;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] field = 8'h50;
  logic [15:0] angle = 16'h0000;
  logic defect_en = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [7:0] x_trim;
  logic [7:0] y_trim;
  logic [15:0] angle_out;
  logic lo_st = 1'b0;
  logic hi_st = 1'b0;
  logic [2:0] lo_c = 3'h0;
  logic [2:0] hi_c = 3'h7;
  logic [15:0] dang [4] = '{16'h1f4a, 16'h6222, 16'h9f4a, 16'he222};
  int err_total = 0;
  int n_checks = 0;

  mfthf_if lnk ();
  mfthf_dev #(.GLITCH_GAP(GAP)) u_mfthf_dev (.i_clk(i_clk), .i_arst_n(i_arst_n), .link(lnk), .i_field_mt(field),
    .i_angle(angle), .i_defect_en(defect_en), .o_x_trim_value(x_trim), .o_y_trim_value(y_trim), .o_angle(angle_out));
  mfthf_host u_mfthf_host (.i_clk(i_clk), .i_arst_n(i_arst_n), .link(lnk), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata));
  mfthf_chk u_mfthf_chk (.i_clk(i_clk), .i_arst_n(i_arst_n), .sclk(lnk.sclk), .cs_n(lnk.cs_n), .mosi(lnk.mosi),
    .miso(lnk.miso), .field_low_flag(lnk.field_low_flag), .field_high_flag(lnk.field_high_flag));

  // 100 MHz clock
  always #5 i_clk = ~i_clk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Host register port cycles
  task automatic hwr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask

  task automatic hrd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    @(posedge i_clk);
    d = rdata;
  endtask

  // Device register access through the host, busy polled with a bound
  task automatic dev_acc(input logic we, input logic [4:0] ra, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] r;
    int n;
    hwr(mfthf_pkg::HREG_CMD, {2'b00, we, ra, d});
    r = 16'h0100;
    for (n = 0; n < 200 && r[8] !== 1'b0; n++) hrd(mfthf_pkg::HREG_RESULT, r);
    q = r[7:0];
    // A stuck host ends the run here, nothing else follows in the task
    if (r[8] !== 1'b0) begin
      err_total++;
      $display("[ERR] %0t device access timed out", $time);
      print_verdict();
    end
  endtask

  // Rising-field switching point of a code
  function automatic logic [7:0] rise_mt(input logic [2:0] c);
    logic [7:0] t [8] = '{8'h1a, 8'h29, 8'h38, 8'h46, 8'h54, 8'h62, 8'h70, 8'h7e};
    return t[c];
  endfunction

  // Applies a field, steps the hysteresis model and checks the pins
  task automatic set_field(input logic [7:0] f);
    @(posedge i_clk);
    field <= f;
    if (f < rise_mt(lo_c) - 8'h06) lo_st = 1'b1;
    else if (f >= rise_mt(lo_c)) lo_st = 1'b0;
    if (f > rise_mt(hi_c)) hi_st = 1'b1;
    else if (f <= rise_mt(hi_c) - 8'h06) hi_st = 1'b0;
    repeat (4) @(posedge i_clk);
    `CHK(lnk.field_low_flag, lo_st)
    `CHK(lnk.field_high_flag, hi_st)
  endtask

  initial begin
    logic [7:0] q;
    logic [7:0] v;
    logic [15:0] r;
    logic prev;
    int i, j, t0, w, np, hc;
    void'($urandom(90715));
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    // Reset contents and an unmapped host address
    dev_acc(1'b0, mfthf_pkg::REG_THRESH, 8'h00, q);
    `CHK(q, mfthf_pkg::THRESH_RESET)
    dev_acc(1'b0, mfthf_pkg::REG_TRIM_EN, 8'h00, q);
    `CHK(q, 8'h00)
    hrd(4'h7, r);
    `CHK(r, 16'h0000)
    $display("test reset done");
    // Every trim enable combination
    for (i = 0; i < 4; i++) begin
      v = 8'($urandom_range(1, 255));
      dev_acc(1'b1, mfthf_pkg::REG_TRIM_VAL, v, q);
      dev_acc(1'b0, mfthf_pkg::REG_TRIM_VAL, 8'h00, q);
      `CHK(q, v)
      dev_acc(1'b1, mfthf_pkg::REG_TRIM_EN, 8'(i), q);
      repeat (3) @(posedge i_clk);
      `CHK(x_trim, i[0] ? v : 8'h00)
      `CHK(y_trim, i[1] ? v : 8'h00)
    end
    $display("test trim done");
    // Random thresholds, first one inverted, fields random or near switching points
    for (i = 0; i < 12; i++) begin
      lo_c = (i == 0) ? 3'h7 : 3'($urandom_range(0, 7));
      hi_c = (i == 0) ? 3'h0 : 3'($urandom_range(0, 7));
      v = {lo_c, hi_c, 2'($urandom_range(0, 3))};
      dev_acc(1'b1, mfthf_pkg::REG_THRESH, v, q);
      dev_acc(1'b0, mfthf_pkg::REG_THRESH, 8'h00, q);
      `CHK(q, {v[7:2], 2'b00})
      set_field(field);
      for (j = 0; j < 4; j++) begin
        angle <= 16'($urandom);
        if ($urandom_range(0, 1)) set_field(8'($urandom_range(0, 150)));
        else set_field(rise_mt($urandom_range(0, 1) ? lo_c : hi_c) - 8'($urandom_range(0, 7)));
        `CHK(angle_out, angle)
        dev_acc(1'b0, mfthf_pkg::REG_STATUS, 8'h00, q);
        `CHK(q, {hi_st, lo_st, 2'b00, ~lo_st, ~lo_st, 2'b00})
        hrd(mfthf_pkg::HREG_FLAGS, r);
        `CHK(r[4:0] & 5'h17, {lo_st, 1'b0, ~hi_st, lo_st, hi_st} & 5'h17)
      end
    end
    $display("test thresholds done");
    // Spurious low pulses in each angle window
    dev_acc(1'b1, mfthf_pkg::REG_THRESH, 8'h1c, q);
    lo_c = 3'h0;
    hi_c = 3'h7;
    set_field(8'h50);
    defect_en <= 1'b1;
    prev = 1'b0;
    t0 = -1;
    w = 0;
    np = 0;
    for (j = 0; j < 3200; j++) begin
      if (j % 800 == 0) angle <= dang[j / 800];
      @(posedge i_clk);
      if (lnk.field_low_flag === 1'b1) begin
        w++;
        if (!prev && t0 >= 0) `CHK((j - t0) >= GAP, 1'b1)
        if (!prev) t0 = j;
        if (!prev) np++;
      end else if (prev) begin
        `CHK(w >= 130 && w <= 150, 1'b1)
        w = 0;
      end
      prev = (lnk.field_low_flag === 1'b1);
    end
    `CHK(np >= 4, 1'b1)
    angle <= 16'h0000;
    repeat (200) @(posedge i_clk);
    hc = 0;
    for (j = 0; j < 800; j++) begin
      @(posedge i_clk);
      if (lnk.field_low_flag !== 1'b0) hc++;
    end
    `CHK(hc, 0)
    $display("test spurious pulses done");
    // Resampled low flag takes a real low field only after the delay
    defect_en <= 1'b0;
    repeat (2100) @(posedge i_clk);
    hrd(mfthf_pkg::HREG_FLAGS, r);
    `CHK(r[3], 1'b0)
    set_field(8'h0a);
    hrd(mfthf_pkg::HREG_FLAGS, r);
    `CHK(r[3:1], 3'h3)
    repeat (2100) @(posedge i_clk);
    hrd(mfthf_pkg::HREG_FLAGS, r);
    `CHK(r[3], 1'b1)
    $display("test resample done");
    print_verdict();
  end
endmodule
`undef CHK
`default_nettype wire
